//--- logic/lsdfp_pkg.sv
// Shared constants of the low-side driver fault protection block.
`default_nettype none
package lsdfp_pkg;
   // Timebase and channel count.
   localparam int CLK_PERIOD_NS = 100;
   localparam int CHANNELS = 8;

   // Overcurrent deglitch, nominal figure, rounded up to whole cycles.
   localparam int OCP_DEGLITCH_NS = 3000;
   localparam int OCP_DEGLITCH_CYCLES = (OCP_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Open-load deglitch, nominal figure, rounded up to whole cycles.
   localparam int OL_DEGLITCH_NS = 17000;
   localparam int OL_DEGLITCH_CYCLES = (OL_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Digital input noise filter: a level must hold this long to be accepted.
   localparam int FILTER_NS = 300;
   localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Chopping periods for 50 kHz, 25 kHz and 12.5 kHz.
   localparam int PWM_FAST_NS = 20000;
   localparam int PWM_MID_NS = 40000;
   localparam int PWM_SLOW_NS = 80000;
   localparam int PWM_FAST_CYCLES = PWM_FAST_NS / CLK_PERIOD_NS;
   localparam int PWM_MID_CYCLES = PWM_MID_NS / CLK_PERIOD_NS;
   localparam int PWM_SLOW_CYCLES = PWM_SLOW_NS / CLK_PERIOD_NS;
   localparam int PWM_DUTY_STEPS = 8;

   // Duty codes in eighths.
   localparam logic [2:0] DUTY_OFF = 3'h0;
   localparam logic [2:0] DUTY_12P5 = 3'h1;
   localparam logic [2:0] DUTY_25 = 3'h2;

   // Clock counts of the four parts of the fault reset command.
   localparam logic [2:0] FRST_PART1 = 3'h1;
   localparam logic [2:0] FRST_PART2 = 3'h2;
   localparam logic [2:0] FRST_PART3 = 3'h4;
   localparam logic [2:0] FRST_PART4 = 3'h3;

   // Fault register layout: open-load bits low, overcurrent bits high.
   localparam int FAULT_OL_LSB = 0;
   localparam int FAULT_OCP_LSB = 8;

   // Reset values.
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage
`default_nettype wire

//--- logic/lsdfp_filter.sv
// Two-flop synchroniser followed by a per-bit stable-level noise filter.
`timescale 1ns/1ns
`default_nettype none
module lsdfp_filter
   import lsdfp_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int FILT_LEN = FILTER_CYCLES
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_nrst,
   // Raw and cleaned levels.
   input wire logic [WIDTH-1:0] i_raw,
   output logic [WIDTH-1:0] o_clean
);
   localparam int CW = 4;

   // Refuse filter lengths the counter cannot hold.
   if (FILT_LEN < 1 || FILT_LEN > 15 || WIDTH < 1) begin : g_chk
      $error("lsdfp_filter: unsupported parameter values");
   end

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] clean;
      logic [WIDTH*CW-1:0] cnt;
   } lsdfp_filt_t;

   lsdfp_filt_t st_reg;
   lsdfp_filt_t st_next;

   // A bit changes only after its synchronised level differs for FILT_LEN cycles.
   always_comb begin
      st_next = st_reg;
      st_next.meta = i_raw;
      st_next.sync = st_reg.meta;
      for (int b = 0; b < WIDTH; b++) begin
         if (st_reg.sync[b] != st_reg.clean[b]) begin
            if (st_reg.cnt[b*CW +: CW] + 4'h1 == CW'(FILT_LEN)) begin
               st_next.clean[b] = st_reg.sync[b];
               st_next.cnt[b*CW +: CW] = 4'h0;
            end else begin
               st_next.cnt[b*CW +: CW] = st_reg.cnt[b*CW +: CW] + 4'h1;
            end
         end else begin
            st_next.cnt[b*CW +: CW] = 4'h0;
         end
      end
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_clean = st_reg.clean;
endmodule
`default_nettype wire

//--- logic/lsdfp_deglitch.sv
// Per-channel persistence timer: a level is reported once it held COUNT cycles.
`timescale 1ns/1ns
`default_nettype none
module lsdfp_deglitch
   import lsdfp_pkg::*;
#(
   parameter int WIDTH = CHANNELS,
   parameter int COUNT = OCP_DEGLITCH_CYCLES
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_nrst,
   // Condition in and persisted condition out.
   input wire logic [WIDTH-1:0] i_cond,
   output logic [WIDTH-1:0] o_hit
);
   localparam int CW = $clog2(COUNT + 1);

   // Refuse counts the timer cannot serve.
   if (COUNT < 1 || WIDTH < 1) begin : g_chk
      $error("lsdfp_deglitch: unsupported parameter values");
   end

   typedef struct packed {
      logic [WIDTH*CW-1:0] cnt;
      logic [WIDTH-1:0] hit;
   } lsdfp_dgl_t;

   lsdfp_dgl_t st_reg;
   lsdfp_dgl_t st_next;

   // Count while the condition holds, restart on any drop.
   always_comb begin
      st_next = st_reg;
      for (int b = 0; b < WIDTH; b++) begin
         if (!i_cond[b]) begin
            st_next.cnt[b*CW +: CW] = '0;
         end else if (st_reg.cnt[b*CW +: CW] != CW'(COUNT)) begin
            st_next.cnt[b*CW +: CW] = st_reg.cnt[b*CW +: CW] + CW'(1);
         end
         st_next.hit[b] = (st_next.cnt[b*CW +: CW] == CW'(COUNT));
      end
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_hit = st_reg.hit;
endmodule
`default_nettype wire

//--- logic/lsdfp_top.sv
// Fault protection, serial front end and chopping of the eight-channel low-side driver.
`timescale 1ns/1ns
`default_nettype none
module lsdfp_top
   import lsdfp_pkg::*;
#(
   parameter int OL_CYCLES = OL_DEGLITCH_CYCLES,
   parameter int OCP_CYCLES = OCP_DEGLITCH_CYCLES
) (
   // Clock and reset.
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   // Serial link pins.
   input wire logic I_SER_CLK,
   input wire logic I_SER_LATCH,
   input wire logic I_CHAIN_SERIAL_IN,
   output logic O_CHAIN_SERIAL_OUT,
   output logic O_CHAIN_SERIAL_OUT_OE_N,
   // Enable pin and chopping configuration.
   input wire logic I_ENABLE,
   input wire logic I_PWM_MODE_EN,
   input wire logic [2:0] I_PWM_DUTY,
   // Analog sense comparators.
   input wire logic [7:0] I_OVERCURRENT,
   input wire logic [7:0] I_OPEN_LOAD_SENSE,
   input wire logic I_THERMAL_SHUTDOWN,
   input wire logic I_SUPPLY_UNDERVOLTAGE_LOCKOUT,
   // Channel drive, fault alarm and status.
   output logic [7:0] O_CHANNEL_ON,
   output logic O_FAULT_ALARM_N,
   output logic O_FAULT_ALARM_N_OE_N,
   output logic [15:0] O_FAULT_FLAGS
);
   localparam logic [11:0] FRST_PATTERN = {FRST_PART1, FRST_PART2, FRST_PART3, FRST_PART4};
   localparam logic [6:0] PWM_FAST_STEP = 7'(PWM_FAST_CYCLES / PWM_DUTY_STEPS);
   localparam logic [6:0] PWM_MID_STEP = 7'(PWM_MID_CYCLES / PWM_DUTY_STEPS);
   localparam logic [6:0] PWM_SLOW_STEP = 7'(PWM_SLOW_CYCLES / PWM_DUTY_STEPS);
   localparam logic [9:0] PWM_FAST_TOP = 10'(PWM_FAST_CYCLES - 1);
   localparam logic [9:0] PWM_MID_TOP = 10'(PWM_MID_CYCLES - 1);
   localparam logic [9:0] PWM_SLOW_TOP = 10'(PWM_SLOW_CYCLES - 1);

   // Refuse deglitch lengths that the timers and the helper counters cannot follow.
   if (OCP_CYCLES < 1 || OL_CYCLES < 1 || OCP_CYCLES > 255 || OL_CYCLES > 255) begin : g_chk
      $error("lsdfp_top: deglitch counts must lie between 1 and 255 cycles");
   end

   typedef struct packed {
      logic sclk_prev;
      logic latch_prev;
      logic [7:0] shift;
      logic [7:0] pending;
      logic [7:0] data;
      logic [2:0] seg_cnt;
      logic [8:0] hist;
      logic freset;
      logic [7:0] overcurrent_flag;
      logic [7:0] ol;
      logic thermal_shutdown;
      logic tsd_hold;
      logic uv;
      logic [9:0] pwm_cnt;
      logic [7:0] chan_on;
      logic alarm_oe_n;
      logic alarm_lvl;
      logic sout_oe_n;
      logic sout_lvl;
      logic [7:0] run0;
      logic [7:0] run_ol0;
   } lsdfp_state_t;

   localparam lsdfp_state_t ST_RESET = '{
      data: DATA_RESET, pending: DATA_RESET, overcurrent_flag: FLAGS_RESET, ol: FLAGS_RESET,
      alarm_oe_n: 1'b1, sout_oe_n: 1'b1, default: '0};

   lsdfp_state_t st_reg;
   lsdfp_state_t st_next;
   logic [3:0] pins_f;
   logic [17:0] sense_s;
   logic [7:0] ocp_cond;
   logic [7:0] ol_cond;
   logic [7:0] ocp_hit;
   logic [7:0] ol_hit;
   logic sclk_rise;
   logic sclk_fall;
   logic latch_rise;
   logic latch_fall;
   logic [9:0] pwm_top;
   logic [9:0] pwm_on;
   logic [7:0] pwm_gate;

   // Serial pins and enable pass the synchroniser and the noise filter.
   lsdfp_filter #(.WIDTH(4), .FILT_LEN(FILTER_CYCLES)) u_pin_filter (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_raw({I_ENABLE, I_CHAIN_SERIAL_IN, I_SER_LATCH, I_SER_CLK}),
      .o_clean(pins_f)
   );

   // Sense comparators are only synchronised; the deglitch timers filter overcurrent and open load, not overtemperature or undervoltage.
   lsdfp_filter #(.WIDTH(18), .FILT_LEN(1)) u_sense_sync (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_raw({I_SUPPLY_UNDERVOLTAGE_LOCKOUT, I_THERMAL_SHUTDOWN, I_OPEN_LOAD_SENSE,
              I_OVERCURRENT}),
      .o_clean(sense_s)
   );

   // Overcurrent counts only while the channel is really driven.
   assign ocp_cond = sense_s[7:0] & st_reg.chan_on;
   // Open load is evaluated only on channels commanded off.
   assign ol_cond = sense_s[15:8] & ~st_reg.data;

   lsdfp_deglitch #(.WIDTH(CHANNELS), .COUNT(OCP_CYCLES)) u_ocp_deglitch (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_cond(ocp_cond),
      .o_hit(ocp_hit)
   );

   lsdfp_deglitch #(.WIDTH(CHANNELS), .COUNT(OL_CYCLES)) u_ol_deglitch (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_cond(ol_cond),
      .o_hit(ol_hit)
   );

   // Edges of the filtered link clock and latch.
   assign sclk_rise = pins_f[0] & ~st_reg.sclk_prev;
   assign sclk_fall = ~pins_f[0] & st_reg.sclk_prev;
   assign latch_rise = pins_f[1] & ~st_reg.latch_prev;
   assign latch_fall = ~pins_f[1] & st_reg.latch_prev;

   // Chopping period and on-time from the duty code.
   always_comb begin
      if (I_PWM_DUTY == DUTY_12P5) begin
         pwm_top = PWM_SLOW_TOP;
         pwm_on = 10'(I_PWM_DUTY) * 10'(PWM_SLOW_STEP);
      end else if (I_PWM_DUTY == DUTY_25) begin
         pwm_top = PWM_MID_TOP;
         pwm_on = 10'(I_PWM_DUTY) * 10'(PWM_MID_STEP);
      end else begin
         pwm_top = PWM_FAST_TOP;
         pwm_on = 10'(I_PWM_DUTY) * 10'(PWM_FAST_STEP);
      end
      if (!I_PWM_MODE_EN) begin
         pwm_gate = 8'hff;
      end else if (I_PWM_DUTY != DUTY_OFF && st_reg.pwm_cnt < pwm_on) begin
         pwm_gate = 8'hff;
      end else begin
         pwm_gate = 8'h00;
      end
   end

   // Next state of the whole block.
   always_comb begin
      st_next = st_reg;
      st_next.freset = 1'b0;
      st_next.sclk_prev = pins_f[0];
      st_next.latch_prev = pins_f[1];
      // Shift in on the rising link clock, count clocks of the current latch part.
      if (sclk_rise) begin
         st_next.shift = {st_reg.shift[6:0], pins_f[2]};
         if (st_reg.seg_cnt != 3'h7) begin
            st_next.seg_cnt = st_reg.seg_cnt + 3'h1;
         end
      end
      // Shift out on the falling edge; a one releases the open-drain line.
      if (sclk_fall) begin
         st_next.sout_oe_n = st_reg.shift[7];
      end
      if (latch_rise) begin
         st_next.pending = st_reg.shift;
      end
      // A plain latch pulse without clocks inside it loads the data register.
      if (latch_fall && st_reg.seg_cnt == 3'h0) begin
         st_next.data = st_reg.pending;
      end
      // Every latch edge closes a part; four matching parts form the fault reset.
      if (latch_rise || latch_fall) begin
         st_next.seg_cnt = 3'h0;
         st_next.hist = {st_reg.hist[5:0], st_reg.seg_cnt};
         if ({st_reg.hist, st_reg.seg_cnt} == FRST_PATTERN) begin
            st_next.freset = 1'b1;
            st_next.hist = '0;
         end
      end
      // Flags: a new event wins over a clear in the same cycle, except that data bit one always clears open load.
      st_next.overcurrent_flag = ocp_hit | (st_reg.overcurrent_flag & st_reg.data & {8{~st_reg.freset}});
      st_next.ol = (ol_hit & ~st_reg.data) | (st_reg.ol & ~st_reg.data & {8{~st_reg.freset}});
      st_next.thermal_shutdown = sense_s[16];
      st_next.tsd_hold = st_reg.thermal_shutdown;
      // Free-running chopping counter.
      if (st_reg.pwm_cnt >= pwm_top) begin
         st_next.pwm_cnt = 10'h000;
      end else begin
         st_next.pwm_cnt = st_reg.pwm_cnt + 10'h001;
      end
      // Drive: data bit, no tripped flag, enable pin, no overtemperature, chopping.
      st_next.chan_on = st_next.data & ~st_next.overcurrent_flag & pwm_gate & {8{pins_f[3] & ~st_next.thermal_shutdown}};
      // Alarm stays low one cycle past overtemperature so outputs resume first.
      st_next.alarm_oe_n = ~(|st_next.overcurrent_flag | |st_next.ol | st_next.thermal_shutdown | st_next.tsd_hold);
      // Helper: consecutive cycles of overcurrent condition on channel 0.
      if (!ocp_cond[0]) begin
         st_next.run0 = 8'h00;
      end else if (st_reg.run0 != 8'hff) begin
         st_next.run0 = st_reg.run0 + 8'h01;
      end
      // Helper: consecutive cycles of open-load condition on channel 0.
      if (!ol_cond[0]) begin
         st_next.run_ol0 = 8'h00;
      end else if (st_reg.run_ol0 != 8'hff) begin
         st_next.run_ol0 = st_reg.run_ol0 + 8'h01;
      end
      // Undervoltage holds the logic in reset without raising the alarm.
      st_next.uv = sense_s[17];
      if (sense_s[17]) begin
         st_next = ST_RESET;
         st_next.uv = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register.
   assign O_CHANNEL_ON = st_reg.chan_on;
   assign O_FAULT_ALARM_N = st_reg.alarm_lvl;
   assign O_FAULT_ALARM_N_OE_N = st_reg.alarm_oe_n;
   assign O_CHAIN_SERIAL_OUT = st_reg.sout_lvl;
   assign O_CHAIN_SERIAL_OUT_OE_N = st_reg.sout_oe_n;
   assign O_FAULT_FLAGS = {st_reg.overcurrent_flag, st_reg.ol};

   // Checks of the protection behaviour.
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_NRST);

   a_ocp_cuts_channel: assert property ((st_reg.overcurrent_flag & st_reg.chan_on) == 8'h00)
      else $error("tripped channel still driven");
   a_ocp_deglitch_len: assert property ($rose(st_reg.overcurrent_flag[0]) |->
      $past(st_reg.run0) >= 8'(OCP_CYCLES))
      else $error("overcurrent flag set before deglitch time");
   a_alarm_on_flag: assert property ((O_FAULT_FLAGS != 16'h0000) |-> !O_FAULT_ALARM_N_OE_N)
      else $error("fault flag set but alarm released");
   a_ocp_clear_off: assert property (st_reg.overcurrent_flag[0] && !st_reg.data[0] |=> !st_reg.overcurrent_flag[0])
      else $error("overcurrent flag not cleared by data bit zero");
   a_reset_clears_all: assert property (st_reg.freset && !st_reg.uv |=>
      (st_reg.overcurrent_flag & ~$past(ocp_hit)) == 8'h00 && (st_reg.ol & ~$past(ol_hit)) == 8'h00)
      else $error("fault reset left flags set");
   a_alarm_release_clean: assert property ($rose(O_FAULT_ALARM_N_OE_N) |->
      O_FAULT_FLAGS == 16'h0000 && !st_reg.thermal_shutdown && !$past(st_reg.thermal_shutdown))
      else $error("alarm released with a fault pending");
   a_ol_only_when_off: assert property ($rose(st_reg.ol[0]) |-> !$past(st_reg.data[0]))
      else $error("open load reported on a channel commanded on");
   a_ol_clear_on: assert property (st_reg.ol[0] && st_reg.data[0] && !ol_hit[0] |=> !st_reg.ol[0])
      else $error("open-load flag not cleared by data bit one");
   a_ol_deglitch_len: assert property ($rose(st_reg.ol[0]) |->
      $past(st_reg.run_ol0) >= 8'(OL_CYCLES))
      else $error("open-load flag set before deglitch time");
   a_reset_whole_reg: assert property (st_reg.freset && !st_reg.uv &&
      ocp_hit == 8'h00 && ol_hit == 8'h00 |=> O_FAULT_FLAGS == 16'h0000)
      else $error("fault reset left part of the fault register set");
   a_tsd_all_off: assert property (st_reg.thermal_shutdown |-> O_CHANNEL_ON == 8'h00 && !O_FAULT_ALARM_N_OE_N)
      else $error("overtemperature left an output on");
   a_tsd_release_late: assert property ($fell(st_reg.thermal_shutdown) |-> !O_FAULT_ALARM_N_OE_N)
      else $error("alarm released before operation resumed");
   a_uv_quiet: assert property (st_reg.uv |-> O_FAULT_ALARM_N_OE_N && O_CHANNEL_ON == 8'h00)
      else $error("undervoltage drove alarm or outputs");
   a_pwm_period: assert property (I_PWM_DUTY == DUTY_25 && st_reg.pwm_cnt == PWM_MID_TOP
      |=> st_reg.pwm_cnt == 10'h000)
      else $error("chopping counter missed its period");

   c_ocp_trip: cover property ($rose(st_reg.overcurrent_flag[0]));
   c_ol_report: cover property ($rose(st_reg.ol[0]));
   c_fault_reset: cover property (st_reg.freset);
   c_tsd_resume: cover property ($fell(st_reg.thermal_shutdown) ##2 O_FAULT_ALARM_N_OE_N);
endmodule
`default_nettype wire

//--- testbench/lsdfp_host.sv
// Host controller model driving the serial pins of one driver.
`timescale 1ns/1ns
`default_nettype none
module lsdfp_host (
   // Host timebase.
   input wire logic i_clk,
   // Serial out line level of the device.
   input wire logic i_sdo,
   // Serial pins towards the device.
   output logic o_ser_clk,
   output logic o_latch,
   output logic o_din
);
   // Bits seen on the serial out line during the last byte.
   logic [7:0] rx;
   // Pins idle low; the data pin has a pull-down, so released means low.
   initial begin
      o_ser_clk = 1'b0;
      o_latch = 1'b0;
      o_din = 1'b0;
      rx = 8'h00;
   end
   // Waits n system clocks, ending just after a falling edge.
   task automatic hold(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // Clocks a byte in, MSB first, and collects the byte pushed out ahead of it.
   task automatic shift_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_din = b[i];
         hold(4);
         o_ser_clk = 1'b1;
         hold(4);
         rx = {rx[6:0], i_sdo};
         o_ser_clk = 1'b0;
      end
      o_din = 1'b0;
   endtask
   // Clock-free latch pulse that moves the shifted byte to the outputs.
   task automatic latch_pulse();
      hold(8);
      o_latch = 1'b1;
      hold(8);
      o_latch = 1'b0;
      hold(12);
   endtask
   // Gives n clock pulses with the data pin low.
   task automatic pulses(input int n);
      repeat (n) begin
         hold(4);
         o_ser_clk = 1'b1;
         hold(4);
         o_ser_clk = 1'b0;
      end
      hold(8);
   endtask
   // Fault reset: parts of 1, 2, 4 and 3 clocks, each closed by a latch edge.
   task automatic fault_reset();
      o_latch = 1'b1;
      hold(8);
      pulses(1);
      o_latch = 1'b0;
      pulses(2);
      o_latch = 1'b1;
      pulses(4);
      o_latch = 1'b0;
      pulses(3);
      o_latch = 1'b1;
      hold(12);
   endtask
   // Closes the latch with a clock inside, so no data is loaded.
   task automatic end_cmd();
      pulses(1);
      o_latch = 1'b0;
      hold(12);
   endtask
   // Two-cycle pulse on the latch or clock pin, shorter than the input filter.
   task automatic glitch(input logic on_latch);
      if (on_latch) o_latch = 1'b1;
      else o_ser_clk = 1'b1;
      hold(2);
      o_latch = 1'b0;
      o_ser_clk = 1'b0;
      hold(12);
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the low-side driver fault protection block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lsdfp_pkg::*;
   // Stimulus and observed signals.
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ser_clk, latch, din, sdo_val, sdo_oe_n, alarm, alarm_oe_n;
   logic en, pwm_en, thermal_shutdown, uv;
   logic [2:0] duty;
   logic [7:0] oc, ol;
   logic [7:0] ch_on;
   logic [15:0] flags;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   // The serial out line has a pull-up, so a release reads high.
   wire sdo_line = sdo_oe_n ? 1'b1 : sdo_val;
   // 10 MHz system clock.
   always #50 clk_sys = ~clk_sys;
   lsdfp_top #(.OL_CYCLES(8), .OCP_CYCLES(4)) dut_u (
      .I_CLK_SYS(clk_sys), .I_NRST(nrst), .I_SER_CLK(ser_clk), .I_SER_LATCH(latch),
      .I_CHAIN_SERIAL_IN(din), .O_CHAIN_SERIAL_OUT(sdo_val),
      .O_CHAIN_SERIAL_OUT_OE_N(sdo_oe_n), .I_ENABLE(en), .I_PWM_MODE_EN(pwm_en),
      .I_PWM_DUTY(duty), .I_OVERCURRENT(oc), .I_OPEN_LOAD_SENSE(ol),
      .I_THERMAL_SHUTDOWN(thermal_shutdown), .I_SUPPLY_UNDERVOLTAGE_LOCKOUT(uv), .O_CHANNEL_ON(ch_on),
      .O_FAULT_ALARM_N(alarm), .O_FAULT_ALARM_N_OE_N(alarm_oe_n), .O_FAULT_FLAGS(flags));
   lsdfp_host host_u (.i_clk(clk_sys), .i_sdo(sdo_line), .o_ser_clk(ser_clk),
      .o_latch(latch), .o_din(din));
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits n cycles, ending just after a falling edge.
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Writes one byte to the output control register.
   task automatic wr(input logic [7:0] b);
      host_u.shift_byte(b);
      host_u.latch_pulse();
   endtask
   // Writes, then checks the byte pushed out of the chain.
   task automatic test_write();
      wr(8'ha5);
      check(16'(ch_on), 16'h00a5);
      host_u.shift_byte(8'h3c);
      check(16'(host_u.rx), 16'h00a5);
      host_u.latch_pulse();
      check(16'(ch_on), 16'h003c);
      $display("test_write done");
   endtask
   // Short pulses on latch and clock must change nothing.
   task automatic test_filter();
      host_u.shift_byte(8'hf0);
      host_u.glitch(1'b1);
      check(16'(ch_on), 16'h003c);
      host_u.glitch(1'b0);
      host_u.latch_pulse();
      check(16'(ch_on), 16'h00f0);
      $display("test_filter done");
   endtask
   // Overcurrent glitch, trip, held alarm and clear by writing zero.
   task automatic test_ocp();
      wr(8'h01);
      oc = 8'h01;
      tick(2);
      oc = 8'h00;
      tick(10);
      check(flags, 16'h0000);
      check(16'(ch_on), 16'h0001);
      oc = 8'h01;
      tick(12);
      check(16'(ch_on), 16'h0000);
      check(flags, 16'h0100);
      check(16'(alarm_oe_n), 16'h0000);
      check(16'(alarm), 16'h0000);
      oc = 8'h00;
      tick(10);
      check(16'(alarm_oe_n), 16'h0000);
      wr(8'h00);
      check(flags, 16'h0000);
      check(16'(alarm_oe_n), 16'h0001);
      $display("test_ocp done");
   endtask
   // Open load only on off channels, after the deglitch, cleared by writing one.
   task automatic test_ol();
      wr(8'h02);
      ol = 8'h03;
      tick(4);
      ol = 8'h00;
      tick(12);
      check(flags, 16'h0000);
      ol = 8'h03;
      tick(20);
      check(flags, 16'h0001);
      check(16'(alarm_oe_n), 16'h0000);
      wr(8'h03);
      check(flags, 16'h0000);
      check(16'(alarm_oe_n), 16'h0001);
      ol = 8'h00;
      $display("test_ol done");
   endtask
   // Fault reset command clears both halves of the fault register.
   task automatic test_freset();
      wr(8'h01);
      oc = 8'h01;
      ol = 8'h04;
      tick(20);
      check(flags, 16'h0104);
      oc = 8'h00;
      ol = 8'h00;
      tick(4);
      host_u.fault_reset();
      check(flags, 16'h0000);
      check(16'(alarm_oe_n), 16'h0001);
      host_u.end_cmd();
      $display("test_freset done");
   endtask
   // Thermal shutdown turns all off; alarm released after outputs resume.
   task automatic test_thermal();
      int n;
      wr(8'h3c);
      thermal_shutdown = 1'b1;
      tick(6);
      check(16'(ch_on), 16'h0000);
      check(16'(alarm_oe_n), 16'h0000);
      thermal_shutdown = 1'b0;
      n = 0;
      while (ch_on !== 8'h3c && n < 10) begin
         tick(1);
         n++;
      end
      check(16'(ch_on), 16'h003c);
      check(16'(alarm_oe_n), 16'h0000);
      tick(1);
      check(16'(alarm_oe_n), 16'h0001);
      $display("test_thermal done");
   endtask
   // Undervoltage clears the logic without raising the alarm.
   task automatic test_uv();
      uv = 1'b1;
      tick(6);
      check(16'(ch_on), 16'h0000);
      check(16'(alarm_oe_n), 16'h0001);
      uv = 1'b0;
      tick(8);
      check(16'(ch_on), 16'h0000);
      check(flags, 16'h0000);
      $display("test_uv done");
   endtask
   // Counts on-cycles and rising edges over one slow period for duty codes 1, 2, 4 and 7.
   task automatic test_pwm();
      logic [2:0] dl [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
      int on_n;
      int rise_n;
      int per;
      logic prev;
      wr(8'h01);
      pwm_en = 1'b1;
      foreach (dl[k]) begin
         duty = dl[k];
         per = (dl[k] == DUTY_12P5) ? PWM_SLOW_CYCLES :
            (dl[k] == DUTY_25) ? PWM_MID_CYCLES : PWM_FAST_CYCLES;
         tick(PWM_SLOW_CYCLES);
         on_n = 0;
         rise_n = 0;
         prev = ch_on[0];
         repeat (PWM_SLOW_CYCLES) begin
            tick(1);
            on_n += int'(ch_on[0] === 1'b1);
            rise_n += int'(ch_on[0] === 1'b1 && prev === 1'b0);
            prev = ch_on[0];
         end
         check(16'(on_n), 16'(PWM_SLOW_CYCLES * dl[k] / PWM_DUTY_STEPS));
         check(16'(rise_n), 16'(PWM_SLOW_CYCLES / per));
      end
      pwm_en = 1'b0;
      $display("test_pwm done");
   endtask
   // A short drop of the enable pin is filtered, a held one turns the outputs off.
   task automatic test_enable();
      en = 1'b0;
      tick(2);
      en = 1'b1;
      tick(10);
      check(16'(ch_on), 16'h0001);
      en = 1'b0;
      tick(10);
      check(16'(ch_on), 16'h0000);
      en = 1'b1;
      tick(10);
      check(16'(ch_on), 16'h0001);
      $display("test_enable done");
   endtask
   // Cuts a hang short.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   // Reset, then every scenario in turn.
   initial begin
      en = 1'b1;
      pwm_en = 1'b0;
      duty = 3'h0;
      oc = 8'h00;
      ol = 8'h00;
      thermal_shutdown = 1'b0;
      uv = 1'b0;
      tick(16);
      nrst = 1'b1;
      tick(8);
      test_write();
      test_filter();
      test_ocp();
      test_ol();
      test_freset();
      test_thermal();
      test_uv();
      test_pwm();
      test_enable();
      print_verdict();
   end
endmodule
`default_nettype wire
